// ---- testbench/asl_mem_model.sv ----
// Behavioural word memory and discrete bit memory facing the unit.
`timescale 1ns/1ps
module asl_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRead,
  input  wire logic        memWrite,
  input  wire logic [15:0] memWdata,
  input  wire logic [1:0]  memByteEn,
  output logic      [15:0] memRdata,
  output logic             memRvalid,
  input  wire logic        bitRead,
  input  wire logic [10:0] bitAddr,
  output logic             bitRdata,
  output logic             bitRvalid
);
  logic [15:0] words [0:65535];
  logic        bits  [0:2047];
  logic [15:0] mA;
  logic [10:0] bA;
  logic [2:0]  mWait, bWait;
  logic        mPend, bPend;
  initial begin
    memRdata = 16'h0;
    bitRdata = 1'b0;
    for (int i = 0; i < 65536; i++) words[i] = 16'(i * 40503);
    for (int i = 0; i < 2048; i++) bits[i] = ^(16'(i * 40503));
  end
  // Idle read lines toggle so a stale value is never taken for an answer.
  always @(posedge clk) begin
    memRvalid <= 1'b0;
    bitRvalid <= 1'b0;
    memRdata  <= ~memRdata;
    bitRdata  <= ~bitRdata;
    if (rst) begin
      mPend <= 1'b0;
      bPend <= 1'b0;
    end else begin
      if (memWrite && memByteEn[0]) words[memAddr][7:0] <= memWdata[7:0];
      if (memWrite && memByteEn[1]) words[memAddr][15:8] <= memWdata[15:8];
      if (memRead) begin
        mPend <= 1'b1;
        mA    <= memAddr;
        mWait <= slow ? 3'h4 : 3'h0;
      end else if (mPend && mWait != 3'h0) mWait <= mWait - 3'h1;
      else if (mPend) begin
        mPend     <= 1'b0;
        memRvalid <= 1'b1;
        memRdata  <= words[mA];
      end
      if (bitRead) begin
        bPend <= 1'b1;
        bA    <= bitAddr;
        bWait <= slow ? 3'h3 : 3'h0;
      end else if (bPend && bWait != 3'h0) bWait <= bWait - 3'h1;
      else if (bPend) begin
        bPend     <= 1'b0;
        bitRvalid <= 1'b1;
        bitRdata  <= bits[bA];
      end
    end
  end
endmodule

// ---- testbench/asl_unit_asserts.sv ----
// Concurrent checks on the ports of the accumulator unit.
`timescale 1ns/1ps
module asl_unit_asserts
  import asl_pkg::*;
#(
  parameter int ADDR_W     = ASL_ADDR_W,
  parameter int BIT_ADDR_W = ASL_BIT_ADDR_W
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  opValid,
  input wire asl_op_t               opCode,
  input wire logic [ADDR_W-1:0]     opAddr,
  input wire logic [BIT_ADDR_W-1:0] opBitAddr,
  input wire logic [5:0]            opBitCount,
  input wire logic                  opReady,
  input wire logic                  opDone,
  input wire logic [ADDR_W-1:0]     memAddr,
  input wire logic                  memRead,
  input wire logic                  memWrite,
  input wire logic [15:0]           memWdata,
  input wire logic [1:0]            memByteEn,
  input wire logic                  bitRead,
  input wire logic [BIT_ADDR_W-1:0] bitAddr,
  input wire logic [31:0]           accumulator,
  input wire logic                  zeroResultFlag,
  input wire logic                  negativeResultFlag,
  input wire logic                  logicErrorFlag
);
  logic take;
  logic goodCnt;
  assign take    = opValid && opReady;
  assign goodCnt = opBitCount >= ASL_BITS_MIN && opBitCount <= ASL_BITS_MAX;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_idx_addr;
    take && opCode == ASL_OP_IDX_STORE |=> !memWrite ||
      (memAddr == $past(opAddr) + $past(accumulator[15:0]) && memByteEn == ASL_BE_WORD);
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");
  property p_idx_acc;
    take && opCode == ASL_OP_IDX_STORE |=> opDone && accumulator == {16'h0, $past(accumulator[15:0])};
  endproperty
  a_idx_acc: assert property (p_idx_acc) else $error("upper half not cleared");
  property p_idx_err;
    take && opCode == ASL_OP_IDX_STORE |=> logicErrorFlag == !memWrite;
  endproperty
  a_idx_err: assert property (p_idx_err) else $error("error flag wrong");
  property p_low;
    take && opCode == ASL_OP_LOW_STORE |=> memWrite && memByteEn == ASL_BE_LOW &&
      memWdata[7:0] == $past(accumulator[7:0]);
  endproperty
  a_low: assert property (p_low) else $error("low byte store wrong");
  property p_high;
    take && opCode == ASL_OP_HIGH_STORE |=> memWrite && memByteEn == ASL_BE_HIGH &&
      memWdata[15:8] == $past(accumulator[15:8]);
  endproperty
  a_high: assert property (p_high) else $error("high byte store wrong");
  property p_and_rd;
    take && opCode inside {ASL_OP_WORD_AND, ASL_OP_DAND_MEM} |=>
      memRead && !opReady && memAddr == $past(opAddr);
  endproperty
  a_and_rd: assert property (p_and_rd) else $error("AND read wrong");
  property p_zero;
    $changed(zeroResultFlag) |-> zeroResultFlag == (accumulator == 32'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_neg;
    $changed(negativeResultFlag) |-> negativeResultFlag == accumulator[ASL_MSB];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_range;
    take && opCode == ASL_OP_RANGE_AND && goodCnt |=> bitRead && bitAddr == $past(opBitAddr);
  endproperty
  a_range: assert property (p_range) else $error("bit read wrong");
  property p_hold;
    !opDone |-> $stable({accumulator, zeroResultFlag, negativeResultFlag, logicErrorFlag});
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without done");
  c_idx: cover property (take && opCode == ASL_OP_IDX_STORE ##1 memWrite);
  c_range: cover property (take && opCode == ASL_OP_RANGE_AND && goodCnt ##[1:200] opDone);
  c_dand: cover property (take && opCode == ASL_OP_DAND_MEM ##[1:50] opDone);
endmodule

bind asl_unit asl_unit_asserts #(.ADDR_W(ADDR_W), .BIT_ADDR_W(BIT_ADDR_W)) u_chk (.*);

// ---- testbench/test_asl_unit.sv ----
// Self-checking bench for the accumulator unit against a behavioural memory.
`timescale 1ns/1ps
module test_asl_unit
  import asl_pkg::*;
;
  logic        clk, rst, slow, opValid, opReady, opDone, memRead, memWrite, memRvalid;
  logic        bitRead, bitRdata, bitRvalid, zeroResultFlag, negativeResultFlag, logicErrorFlag;
  asl_op_t     opCode;
  logic [15:0] opAddr, memAddr, memWdata, memRdata;
  logic [10:0] opBitAddr, bitAddr;
  logic [5:0]  opBitCount;
  logic [31:0] opConst, accumulator, accE, r;
  logic [1:0]  memByteEn;
  logic        zE, nE, eE, lastLoad;
  logic [31:0] stk[$];
  logic [5:0]  cornerCnt [4] = '{6'h00, 6'h01, 6'h20, 6'h21};
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          seed = 32'h902d936c;
  asl_unit dut (.*);
  asl_mem_model mem (.*);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpFlag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Work out the expected result first, then drive one request and check it.
  task automatic runOp(input asl_op_t op, input logic [15:0] a, input logic [10:0] b,
                       input logic [5:0] c, input logic [31:0] k);
    logic [31:0] top, msk;
    logic [16:0] sum;
    logic [15:0] wAddr, wExp;
    logic        wChk, wz, wn;
    int          n;
    top   = (stk.size() > 0) ? stk[0] : 32'h0;
    wChk  = 1'b0;
    wz    = 1'b0;
    wn    = 1'b0;
    wAddr = a;
    wExp  = 16'h0;
    msk   = 32'h0;
    for (int i = 0; i < 32; i++) if (i < c) msk[i] = mem.bits[11'(b + i)];
    case (op)
      ASL_OP_POP, ASL_OP_STACK_AND: begin
        accE = (op == ASL_OP_POP) ? top : accE & top;
        if (stk.size() > 0) void'(stk.pop_front());
        wz = 1'b1;
        wn = (op == ASL_OP_STACK_AND);
      end
      ASL_OP_WORD_LOAD: begin
        if (lastLoad) stk.push_front(accE);
        if (stk.size() > ASL_STACK_DEPTH) void'(stk.pop_back());
        accE = {16'h0, k[15:0]};
      end
      ASL_OP_IDX_STORE: begin
        sum   = {1'b0, a} + {1'b0, accE[15:0]};
        eE    = (stk.size() == 0) || sum[16];
        wChk  = !eE;
        wAddr = sum[15:0];
        wExp  = top[15:0];
        accE[31:16] = 16'h0;
      end
      ASL_OP_LOW_STORE: begin
        wChk = 1'b1;
        wExp = {mem.words[a][15:8], accE[7:0]};
      end
      ASL_OP_HIGH_STORE: begin
        wChk = 1'b1;
        wExp = {accE[15:8], mem.words[a][7:0]};
      end
      ASL_OP_WORD_AND: begin
        accE = {16'h0, accE[15:0] & mem.words[a]};
        wz   = 1'b1;
      end
      ASL_OP_DAND_MEM, ASL_OP_DAND_CONST: begin
        accE = accE & ((op == ASL_OP_DAND_CONST) ? k : {mem.words[a + 16'h1], mem.words[a]});
        wz   = 1'b1;
        wn   = 1'b1;
      end
      ASL_OP_RANGE_AND: begin
        wz = (c >= ASL_BITS_MIN) && (c <= ASL_BITS_MAX);
        wn = wz;
        if (wz) accE = accE & msk;
        else eE = 1'b1;
      end
      default: ;
    endcase
    if (wz) zE = (accE == 32'h0);
    if (wn) nE = accE[31];
    lastLoad = (op == ASL_OP_WORD_LOAD);
    @(negedge clk);
    opValid    = 1'b1;
    opCode     = op;
    opAddr     = a;
    opBitAddr  = b;
    opBitCount = c;
    opConst    = k;
    n = 0;
    while (opReady !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    opValid = 1'b0;
    while (opDone !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    cmpFlag(opDone, 1'b1);
    cmpWord(accumulator, accE);
    cmpFlag(zeroResultFlag, zE);
    cmpFlag(negativeResultFlag, nE);
    cmpFlag(logicErrorFlag, eE);
    @(negedge clk);
    if (wChk) cmpWord({16'h0, mem.words[wAddr]}, {16'h0, wExp});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    {rst, zE, nE, eE, lastLoad, accE} = {1'b1, 36'h0};
    {slow, opValid, opAddr, opBitAddr, opBitCount, opConst} = '0;
    opCode = ASL_OP_NOP;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    runOp(ASL_OP_STACK_AND, 16'h0, 11'h0, 6'h0, 32'h0);
    runOp(ASL_OP_WORD_LOAD, 16'h0, 11'h0, 6'h0, 32'h1234);
    runOp(ASL_OP_WORD_LOAD, 16'h0, 11'h0, 6'h0, 32'h0010);
    runOp(ASL_OP_IDX_STORE, 16'h0100, 11'h0, 6'h0, 32'h0);
    runOp(ASL_OP_POP, 16'h0, 11'h0, 6'h0, 32'h0);
    runOp(ASL_OP_WORD_LOAD, 16'h0, 11'h0, 6'h0, 32'hfff0);
    runOp(ASL_OP_IDX_STORE, 16'h0020, 11'h0, 6'h0, 32'h0);
    foreach (cornerCnt[i]) begin
      runOp(ASL_OP_RANGE_AND, 16'h0, 11'h7f8, cornerCnt[i], 32'h0);
    end
    repeat (10) runOp(ASL_OP_WORD_LOAD, 16'h0, 11'h0, 6'h0, $random(seed));
    repeat (9) runOp(ASL_OP_POP, 16'h0, 11'h0, 6'h0, 32'h0);
    repeat (300) begin
      r    = $random(seed);
      slow = r[31];
      runOp(asl_op_t'(4'(r[7:0] % 8'd11)), r[20] ? {8'h0, r[15:8]} : r[31:16],
            r[26:16], r[13:8] % 6'd36, $random(seed));
    end
    summarize();
  end
endmodule

// ---- verilog/asl_pkg.sv ----
// Shared constants and types of the accumulator store and logic unit.
package asl_pkg;
  localparam int          ASL_DATA_W      = 32;
  localparam int          ASL_WORD_W      = 16;
  localparam int          ASL_ADDR_W      = 16;
  localparam int          ASL_BIT_ADDR_W  = 11;
  localparam int          ASL_STACK_DEPTH = 8;
  localparam int          ASL_CNT_W       = 6;
  localparam logic [31:0] ASL_ACC_RESET   = 32'h0000_0000;
  localparam logic [15:0] ASL_WORD_RESET  = 16'h0000;
  localparam logic [5:0]  ASL_BITS_MIN    = 6'h01;
  localparam logic [5:0]  ASL_BITS_MAX    = 6'h20;
  localparam logic [1:0]  ASL_BE_NONE     = 2'h0;
  localparam logic [1:0]  ASL_BE_LOW      = 2'h1;
  localparam logic [1:0]  ASL_BE_HIGH     = 2'h2;
  localparam logic [1:0]  ASL_BE_WORD     = 2'h3;
  localparam int          ASL_MSB         = 31;

  typedef enum logic [3:0] {
    ASL_OP_NOP         = 4'h0,
    ASL_OP_POP         = 4'h1,
    ASL_OP_WORD_LOAD   = 4'h2,
    ASL_OP_IDX_STORE   = 4'h3,
    ASL_OP_LOW_STORE   = 4'h4,
    ASL_OP_HIGH_STORE  = 4'h5,
    ASL_OP_WORD_AND    = 4'h6,
    ASL_OP_DAND_MEM    = 4'h7,
    ASL_OP_DAND_CONST  = 4'h8,
    ASL_OP_RANGE_AND   = 4'h9,
    ASL_OP_STACK_AND   = 4'ha
  } asl_op_t;

  typedef enum logic [4:0] {
    ASL_ST_IDLE   = 5'h01,
    ASL_ST_WORD   = 5'h02,
    ASL_ST_DLO    = 5'h04,
    ASL_ST_DHI    = 5'h08,
    ASL_ST_BITS   = 5'h10
  } asl_state_t;
endpackage

// ---- verilog/asl_stack.sv ----
// Accumulator stack with shift-on-push and shift-on-pop levels.
`timescale 1ns/1ps
module asl_stack
  import asl_pkg::*;
#(
  parameter int DEPTH = ASL_STACK_DEPTH
) (
  input  wire logic  clk,
  input  wire logic  rst,
  asl_stack_if.store stk
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [31:0]   level_q [DEPTH];
  logic [CW-1:0] count_q;

  assign stk.top   = (count_q == CNT_ZERO) ? ASL_ACC_RESET : level_q[0];
  assign stk.empty = (count_q == CNT_ZERO);

  // A pop moves every deeper entry one level toward the top. [RULE_02]
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gLevel
      always_ff @(posedge clk) begin
        if (rst) begin
          level_q[g] <= ASL_ACC_RESET;
        end else if (stk.push) begin
          level_q[g] <= (g == 0) ? stk.pushData : level_q[(g == 0) ? 0 : g - 1];
        end else if (stk.pop) begin
          level_q[g] <= (g == DEPTH - 1) ? ASL_ACC_RESET : level_q[(g == DEPTH - 1) ? g : g + 1];
        end
      end
    end
  endgenerate

  // A push into a full stack drops the bottom entry, as a shift register would.
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= CNT_ZERO;
    end else if (stk.push && count_q != CNT_FULL) begin
      count_q <= count_q + CNT_ONE;
    end else if (stk.pop && !stk.push && count_q != CNT_ZERO) begin
      count_q <= count_q - CNT_ONE;
    end
  end
endmodule

// ---- verilog/asl_stack_if.sv ----
// Connection between the sequencing datapath and the accumulator stack.
`timescale 1ns/1ps
interface asl_stack_if;
  logic        push;
  logic        pop;
  logic [31:0] pushData;
  logic [31:0] top;
  logic        empty;

  modport ctrl  (output push, output pop, output pushData, input top, input empty);
  modport store (input push, input pop, input pushData, output top, output empty);
endinterface

// ---- verilog/asl_unit.sv ----
// Accumulator datapath for pop, stores and the AND family of operations.
//
// Function
// RULE_01 - Pop moves top stack level into accumulator.
// RULE_02 - Pop shifts remaining stack entries up one.
// RULE_03 - Indexed store writes top word at base+accumulator.
// RULE_04 - Indexed offset is added as plain binary.
// RULE_05 - Indexed store clears accumulator upper sixteen bits.
// RULE_06 - Indexed store failure sets logic error flag.
// RULE_07 - Back-to-back loads push first value onto stack.
// RULE_08 - Low byte store writes accumulator bits 7..0.
// RULE_09 - High byte store writes accumulator bits 15..8.
// RULE_10 - Byte stores leave the other byte untouched.
// RULE_11 - Word AND combines low accumulator word with memory.
// RULE_12 - Word AND sets zero flag on zero result.
// RULE_13 - Double AND with two words or constant.
// RULE_14 - Double AND updates zero and negative flags.
// RULE_15 - Range AND with 1 to 32 discrete bits.
// RULE_16 - Range AND updates zero and negative flags.
// RULE_17 - Stack AND combines with top, then pops.
// RULE_18 - Stack AND updates zero and negative flags.
// RULE_19 - Flags hold until the next writer overwrites them.
`timescale 1ns/1ps
module asl_unit
  import asl_pkg::*;
#(
  parameter int STACK_DEPTH = ASL_STACK_DEPTH,
  parameter int ADDR_W      = ASL_ADDR_W,
  parameter int BIT_ADDR_W  = ASL_BIT_ADDR_W
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  opValid,
  input  wire asl_op_t               opCode,
  input  wire logic [ADDR_W-1:0]     opAddr,
  input  wire logic [BIT_ADDR_W-1:0] opBitAddr,
  input  wire logic [5:0]            opBitCount,
  input  wire logic [31:0]           opConst,
  output logic                       opReady,
  output logic                       opDone,
  output logic [ADDR_W-1:0]          memAddr,
  output logic                       memRead,
  output logic                       memWrite,
  output logic [15:0]                memWdata,
  output logic [1:0]                 memByteEn,
  input  wire logic [15:0]           memRdata,
  input  wire logic                  memRvalid,
  output logic                       bitRead,
  output logic [BIT_ADDR_W-1:0]      bitAddr,
  input  wire logic                  bitRdata,
  input  wire logic                  bitRvalid,
  output logic [31:0]                accumulator,
  output logic                       zeroResultFlag,
  output logic                       negativeResultFlag,
  output logic                       logicErrorFlag
);
  localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'(1);

  asl_stack_if stk ();

  asl_stack #(
    .DEPTH (STACK_DEPTH)
  ) uStack (
    .clk (clk),
    .rst (rst),
    .stk (stk.store)
  );

  asl_state_t              state_q;
  asl_state_t              state_d;
  logic [31:0]             acc_q;
  logic [31:0]             acc_d;
  logic                    zero_q;
  logic                    neg_q;
  logic                    err_q;
  logic                    zeroWe;
  logic                    negWe;
  logic                    errWe;
  logic                    errSet;
  logic                    done_q;
  logic                    done_d;
  logic                    ready_q;
  logic                    loadSeen_q;
  logic                    loadSeen_d;
  logic [15:0]             loWord_q;
  logic [15:0]             loWord_d;
  logic [31:0]             gather_q;
  logic [31:0]             gather_d;
  logic [5:0]              idx_q;
  logic [5:0]              idx_d;
  logic [5:0]              cnt_q;
  logic [5:0]              cnt_d;
  logic [BIT_ADDR_W-1:0]   bitBase_q;
  logic [BIT_ADDR_W-1:0]   bitBase_d;
  logic [ADDR_W-1:0]       memAddr_q;
  logic [ADDR_W-1:0]       memAddr_d;
  logic                    memRead_q;
  logic                    memRead_d;
  logic                    memWrite_q;
  logic                    memWrite_d;
  logic [15:0]             memWdata_q;
  logic [15:0]             memWdata_d;
  logic [1:0]              memBe_q;
  logic [1:0]              memBe_d;
  logic                    bitRead_q;
  logic                    bitRead_d;
  logic [BIT_ADDR_W-1:0]   bitAddr_q;
  logic [BIT_ADDR_W-1:0]   bitAddr_d;
  logic [ADDR_W:0]         idxSum;
  logic [31:0]             res;
  logic [31:0]             bitWord;
  logic                    accept;

  function automatic logic isZero(input logic [31:0] v);
    isZero = (v == ASL_ACC_RESET);
  endfunction

  function automatic logic bitsInRange(input logic [5:0] n);
    bitsInRange = (n >= ASL_BITS_MIN) && (n <= ASL_BITS_MAX);
  endfunction

  assign accept  = opValid && (state_q == ASL_ST_IDLE);
  // The offset is an unsigned binary value; no decimal correction is applied. [RULE_04]
  assign idxSum  = {1'b0, opAddr} + {1'b0, acc_q[ADDR_W-1:0]};
  assign bitWord = {31'h0000_0000, bitRdata} << idx_q[4:0];

  always_comb begin
    state_d      = state_q;
    acc_d        = acc_q;
    res          = acc_q;
    zeroWe       = 1'b0;
    negWe        = 1'b0;
    errWe        = 1'b0;
    errSet       = 1'b0;
    done_d       = 1'b0;
    loadSeen_d   = loadSeen_q;
    loWord_d     = loWord_q;
    gather_d     = gather_q;
    idx_d        = idx_q;
    cnt_d        = cnt_q;
    bitBase_d    = bitBase_q;
    memAddr_d    = memAddr_q;
    memRead_d    = 1'b0;
    memWrite_d   = 1'b0;
    memWdata_d   = memWdata_q;
    memBe_d      = ASL_BE_NONE;
    bitRead_d    = 1'b0;
    bitAddr_d    = bitAddr_q;
    stk.push     = 1'b0;
    stk.pop      = 1'b0;
    stk.pushData = acc_q;
    case (state_q)
      ASL_ST_IDLE: begin
        if (accept) begin
          loadSeen_d = 1'b0;
          case (opCode)
            ASL_OP_POP: begin
              acc_d   = stk.top; // [RULE_01]
              stk.pop = 1'b1; // [RULE_02]
              zeroWe  = 1'b1;
              done_d  = 1'b1;
            end
            ASL_OP_WORD_LOAD: begin
              // A load directly after a load saves the earlier value first. [RULE_07]
              stk.push   = loadSeen_q;
              acc_d      = {16'h0000, opConst[15:0]};
              loadSeen_d = 1'b1;
              done_d     = 1'b1;
            end
            ASL_OP_IDX_STORE: begin
              acc_d  = {16'h0000, acc_q[15:0]}; // [RULE_05]
              errWe  = 1'b1;
              // An empty stack or an address past the top of memory cannot complete. [RULE_06]
              errSet = stk.empty || idxSum[ADDR_W];
              if (!errSet) begin
                memAddr_d  = idxSum[ADDR_W-1:0]; // [RULE_03]
                memWdata_d = stk.top[15:0]; // [RULE_03]
                memBe_d    = ASL_BE_WORD;
                memWrite_d = 1'b1;
              end
              done_d = 1'b1;
            end
            ASL_OP_LOW_STORE: begin
              memAddr_d  = opAddr;
              memWdata_d = acc_q[15:0];
              memBe_d    = ASL_BE_LOW; // [RULE_08] [RULE_10]
              memWrite_d = 1'b1;
              done_d     = 1'b1;
            end
            ASL_OP_HIGH_STORE: begin
              memAddr_d  = opAddr;
              memWdata_d = acc_q[15:0];
              memBe_d    = ASL_BE_HIGH; // [RULE_09] [RULE_10]
              memWrite_d = 1'b1;
              done_d     = 1'b1;
            end
            ASL_OP_WORD_AND: begin
              memAddr_d = opAddr;
              memRead_d = 1'b1;
              state_d   = ASL_ST_WORD;
            end
            ASL_OP_DAND_MEM: begin
              memAddr_d = opAddr;
              memRead_d = 1'b1;
              state_d   = ASL_ST_DLO;
            end
            ASL_OP_DAND_CONST: begin
              acc_d  = acc_q & opConst; // [RULE_13]
              zeroWe = 1'b1; // [RULE_14]
              negWe  = 1'b1; // [RULE_14]
              done_d = 1'b1;
            end
            ASL_OP_RANGE_AND: begin
              if (bitsInRange(opBitCount)) begin // [RULE_15]
                bitBase_d = opBitAddr;
                bitAddr_d = opBitAddr;
                bitRead_d = 1'b1;
                idx_d     = 6'h00;
                cnt_d     = opBitCount;
                gather_d  = ASL_ACC_RESET;
                state_d   = ASL_ST_BITS;
              end else begin
                // A count outside 1..32 is refused and the accumulator is left alone.
                errWe  = 1'b1;
                errSet = 1'b1;
                done_d = 1'b1;
              end
            end
            ASL_OP_STACK_AND: begin
              acc_d   = acc_q & stk.top; // [RULE_17]
              stk.pop = 1'b1; // [RULE_17]
              zeroWe  = 1'b1; // [RULE_18]
              negWe   = 1'b1; // [RULE_18]
              done_d  = 1'b1;
            end
            default: begin
              done_d = 1'b1;
            end
          endcase
        end
      end
      ASL_ST_WORD: begin
        if (memRvalid) begin
          acc_d   = {16'h0000, acc_q[15:0] & memRdata}; // [RULE_11]
          zeroWe  = 1'b1; // [RULE_12]
          done_d  = 1'b1;
          state_d = ASL_ST_IDLE;
        end
      end
      ASL_ST_DLO: begin
        if (memRvalid) begin
          loWord_d  = memRdata;
          memAddr_d = memAddr_q + ADDR_ONE;
          memRead_d = 1'b1;
          state_d   = ASL_ST_DHI;
        end
      end
      ASL_ST_DHI: begin
        if (memRvalid) begin
          acc_d   = acc_q & {memRdata, loWord_q}; // [RULE_13]
          zeroWe  = 1'b1; // [RULE_14]
          negWe   = 1'b1; // [RULE_14]
          done_d  = 1'b1;
          state_d = ASL_ST_IDLE;
        end
      end
      ASL_ST_BITS: begin
        if (bitRvalid) begin
          res = gather_q | bitWord;
          gather_d = res;
          if (idx_q + 6'h01 == cnt_q) begin
            acc_d   = acc_q & res; // [RULE_15]
            zeroWe  = 1'b1; // [RULE_16]
            negWe   = 1'b1; // [RULE_16]
            done_d  = 1'b1;
            state_d = ASL_ST_IDLE;
          end else begin
            idx_d     = idx_q + 6'h01;
            bitAddr_d = bitBase_q + BIT_ADDR_W'(idx_q + 6'h01);
            bitRead_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ASL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q    <= ASL_ST_IDLE;
      ready_q    <= 1'b1;
      done_q     <= 1'b0;
      loadSeen_q <= 1'b0;
      loWord_q   <= ASL_WORD_RESET;
      gather_q   <= ASL_ACC_RESET;
      idx_q      <= 6'h00;
      cnt_q      <= 6'h00;
      bitBase_q  <= '0;
    end else begin
      state_q    <= state_d;
      ready_q    <= (state_d == ASL_ST_IDLE);
      done_q     <= done_d;
      loadSeen_q <= loadSeen_d;
      loWord_q   <= loWord_d;
      gather_q   <= gather_d;
      idx_q      <= idx_d;
      cnt_q      <= cnt_d;
      bitBase_q  <= bitBase_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_q <= ASL_ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Each flag is written only by operations that own it, so it holds otherwise. [RULE_19]
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_q <= 1'b0;
      neg_q  <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      if (zeroWe) begin
        zero_q <= isZero(acc_d); // [RULE_12] [RULE_14] [RULE_16] [RULE_18]
      end
      if (negWe) begin
        neg_q <= acc_d[ASL_MSB]; // [RULE_14] [RULE_16] [RULE_18]
      end
      if (errWe) begin
        err_q <= errSet; // [RULE_06]
      end
    end
  end

  // Port strobes are registered so the memory sees clean single-cycle pulses.
  always_ff @(posedge clk) begin
    if (rst) begin
      memAddr_q  <= '0;
      memRead_q  <= 1'b0;
      memWrite_q <= 1'b0;
      memWdata_q <= ASL_WORD_RESET;
      memBe_q    <= ASL_BE_NONE;
      bitRead_q  <= 1'b0;
      bitAddr_q  <= '0;
    end else begin
      memAddr_q  <= memAddr_d;
      memRead_q  <= memRead_d;
      memWrite_q <= memWrite_d;
      memWdata_q <= memWdata_d;
      memBe_q    <= memBe_d;
      bitRead_q  <= bitRead_d;
      bitAddr_q  <= bitAddr_d;
    end
  end

  assign opReady            = ready_q;
  assign opDone             = done_q;
  assign memAddr            = memAddr_q;
  assign memRead            = memRead_q;
  assign memWrite           = memWrite_q;
  assign memWdata           = memWdata_q;
  assign memByteEn          = memBe_q;
  assign bitRead            = bitRead_q;
  assign bitAddr            = bitAddr_q;
  assign accumulator        = acc_q;
  assign zeroResultFlag     = zero_q;
  assign negativeResultFlag = neg_q;
  assign logicErrorFlag     = err_q;
endmodule
